//--- hdl/charger_ctrl.sv
// charger mode selection, charge phases, safety timers and switching control
// assumes comparator inputs and the serial link strobe come from other domains
// Overview of operation
// - a charge start from idle begins the long window and any host write cancels it.
// - cancelling the long window starts the host watchdog window at once.
// - host writes one to the kick bit, the window restarts and the bit self-clears.
// - watchdog expiry ends charge, restores defaults, restarts long window, resumes.
// - long window expiry stops charge, sets a fault code and pulses the indicator.
// - timer fault clears only at power-on; fault status holds until host reads it.
// - recharge drop, power-on with low battery, enable toggle or reset start a cycle.
// - with termination enabled, termination current above recharge level ends charge.
// - below short threshold use reduced current, above it ramp to fast charge.
// - the converter switches at a fixed frequency with duty from zero to the maximum.
// - low-side switch runs only while its current exceeds the threshold.
// - charge, boost and high-impedance modes exist; without boost only two.
// - high-impedance mode halts charging and boosting.
// - regulation voltage target is host programmable within its range.
// - in the long window with battery above low threshold stay high-impedance.
// - indicator pulled low while charging when enabled or during the fault pulse, otherwise released.
`timescale 1ns/1ps
`include "charger_ctrl_params.svh"
module charger_ctrl #(
  parameter bit HAS_BOOST = 1'b1,
  parameter int PRESCALE = `PRESCALE_CYCLES,
  parameter int LONG_TICKS = `LONG_WINDOW_TICKS,
  parameter int WDOG_TICKS = `WDOG_WINDOW_TICKS,
  parameter int PULSE_CYCLES = `FAULT_PULSE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic host_write_evt,
  input wire charger_ctrl_pkg::sense_type sense_in,
  output logic irq,
  output logic stat_out,
  output logic stat_oe_n,
  output logic charge_on,
  output logic short_current,
  output logic fast_current,
  output logic boost_on,
  output logic hiz_on,
  output logic high_side_on,
  output logic low_side_on,
  output logic [15:0] vreg_target_mv
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  charger_ctrl_pkg::sense_type sense_s1_ff, sense_ff;
  logic hw_s1_ff, hw_s2_ff, hw_s3_ff;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sense_s1_ff <= '0;
      sense_ff <= '0;
      hw_s1_ff <= 1'b0;
      hw_s2_ff <= 1'b0;
      hw_s3_ff <= 1'b0;
    end else begin
      sense_s1_ff <= sense_in;
      sense_ff <= sense_s1_ff;
      hw_s1_ff <= host_write_evt;
      hw_s2_ff <= hw_s1_ff;
      hw_s3_ff <= hw_s2_ff;
    end
  end
  wire host_write = hw_s2_ff & ~hw_s3_ff;

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [15:0] vreg_ff;
  logic [15:0] duty_ff;
  logic [3:0] irq_stat_ff, irq_mask_ff;
  logic [1:0] stat_code_ff;
  logic stat_read_ff;
  logic wdog_mode_ff;
  charger_ctrl_pkg::phase_type phase_ff, nxt_phase;
  charger_ctrl_pkg::op_mode_type mode;
  logic long_exp, wdog_exp, restart, start_cycle, pulse_start;
  wire wr_ctrl = reg_wr && reg_addr == `ADDR_CTRL;
  wire wr_vreg = reg_wr && reg_addr == `ADDR_VREG;
  wire wr_duty = reg_wr && reg_addr == `ADDR_DUTY;
  wire wr_istat = reg_wr && reg_addr == `ADDR_IRQ_STAT;
  wire wr_imask = reg_wr && reg_addr == `ADDR_IRQ_MASK;
  wire rd_status = reg_rd && reg_addr == `ADDR_STATUS;
  wire [15:0] vreg_clip = reg_wdata < 16'(`VREG_MIN_MV) ? 16'(`VREG_MIN_MV) :
                          reg_wdata > 16'(`VREG_MAX_MV) ? 16'(`VREG_MAX_MV) : reg_wdata;
  wire [15:0] duty_clip = reg_wdata > 16'(`DUTY_MAX_PERMILLE) ?
                          16'(`DUTY_MAX_PERMILLE) : reg_wdata;
  wire [15:0] status_word = {9'h000, wdog_mode_ff, 1'b0, phase_ff, stat_code_ff};
  logic [15:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      `ADDR_CTRL: rd_mux = {8'h00, ctrl_ff};
      `ADDR_VREG: rd_mux = vreg_ff;
      `ADDR_STATUS: rd_mux = status_word;
      `ADDR_IRQ_STAT: rd_mux = {12'h000, irq_stat_ff};
      `ADDR_IRQ_MASK: rd_mux = {12'h000, irq_mask_ff};
      `ADDR_DUTY: rd_mux = duty_ff;
      default: rd_mux = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  // defaults restored
  wire restore_defaults = wdog_exp;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= `CTRL_RESET_VAL;
      vreg_ff <= 16'(`VREG_DEFAULT_MV);
      duty_ff <= 16'h0000;
      irq_mask_ff <= 4'h0;
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      if (wr_imask)
        irq_mask_ff <= reg_wdata[3:0];
      if (restore_defaults) begin
        ctrl_ff <= `CTRL_RESET_VAL;
        vreg_ff <= 16'(`VREG_DEFAULT_MV);
      end else begin
        if (wr_vreg)
          vreg_ff <= vreg_clip;
        if (wr_ctrl)
          ctrl_ff <= {1'b0, reg_wdata[6:0]};
        else if (ctrl_ff[`CTRL_KICK])
          ctrl_ff[`CTRL_KICK] <= 1'b0;
        if (ctrl_ff[`CTRL_RESET] && !wr_ctrl)
          ctrl_ff[`CTRL_RESET] <= 1'b0;
      end
      if (wr_duty)
        duty_ff <= duty_clip;
    end
  end

  // ------------------------------------------------------------
  // mode and phase
  // ------------------------------------------------------------
  logic chg_en_d_ff;
  // power-on check waits until the sense synchroniser holds real levels
  logic [2:0] por_sr_ff;
  wire por_check = por_sr_ff[2];
  charger_ctrl_pkg::phase_type start_phase;
  wire auto_hiz = !wdog_mode_ff && !sense_ff.below_lowbat;
  always_comb begin
    if (ctrl_ff[`CTRL_HIZ] || auto_hiz)
      mode = charger_ctrl_pkg::mode_hiz_type;
    else if (HAS_BOOST && ctrl_ff[`CTRL_BOOST])
      mode = charger_ctrl_pkg::mode_boost_type;
    else
      mode = charger_ctrl_pkg::mode_charge_type;
  end
  wire charge_mode = mode == charger_ctrl_pkg::mode_charge_type;
  assign start_cycle = (chg_en_d_ff != ctrl_ff[`CTRL_CHG_EN]) || ctrl_ff[`CTRL_RESET] ||
                       (por_check && sense_ff.below_lowbat) ||
                       (phase_ff == charger_ctrl_pkg::ph_done && sense_ff.below_recharge);
  // reduced current only while the battery really sits below the short level
  assign start_phase = sense_ff.below_short ? charger_ctrl_pkg::ph_short :
                       charger_ctrl_pkg::ph_fast;
  always_comb begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      charger_ctrl_pkg::ph_idle:
        if (start_cycle)
          nxt_phase = start_phase;
      charger_ctrl_pkg::ph_short:
        if (!sense_ff.below_short)
          nxt_phase = charger_ctrl_pkg::ph_fast;
      charger_ctrl_pkg::ph_fast:
        if (ctrl_ff[`CTRL_TERM_EN] && sense_ff.term_current && !sense_ff.below_recharge)
          nxt_phase = charger_ctrl_pkg::ph_done;
        else if (sense_ff.below_short)
          nxt_phase = charger_ctrl_pkg::ph_short;
      charger_ctrl_pkg::ph_done:
        if (start_cycle)
          nxt_phase = start_phase;
      charger_ctrl_pkg::ph_fault:
        nxt_phase = charger_ctrl_pkg::ph_fault;
      default:
        nxt_phase = charger_ctrl_pkg::ph_idle;
    endcase
    if (long_exp)
      nxt_phase = charger_ctrl_pkg::ph_fault;
    else if (wdog_exp && phase_ff != charger_ctrl_pkg::ph_fault)
      nxt_phase = start_phase;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= charger_ctrl_pkg::ph_idle;
      chg_en_d_ff <= 1'b0;
      por_sr_ff <= 3'h1;
    end else begin
      phase_ff <= nxt_phase;
      chg_en_d_ff <= ctrl_ff[`CTRL_CHG_EN];
      por_sr_ff <= {por_sr_ff[1:0], 1'b0};
    end
  end
  wire charging = charge_mode && (phase_ff == charger_ctrl_pkg::ph_short ||
                                  phase_ff == charger_ctrl_pkg::ph_fast);
  assign restart = phase_ff == charger_ctrl_pkg::ph_idle && nxt_phase != phase_ff;

  // ------------------------------------------------------------
  // safety timers
  // ------------------------------------------------------------
  logic [$clog2(PRESCALE)-1:0] pre_ff;
  logic [31:0] win_ff;
  wire tick = pre_ff == ($clog2(PRESCALE))'(PRESCALE - 1);
  wire timer_run = phase_ff != charger_ctrl_pkg::ph_fault && phase_ff != charger_ctrl_pkg::ph_idle;
  assign long_exp = timer_run && !wdog_mode_ff && tick && win_ff == 32'(LONG_TICKS - 1);
  assign wdog_exp = timer_run && wdog_mode_ff && tick && win_ff == 32'(WDOG_TICKS - 1);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pre_ff <= '0;
      win_ff <= 32'h00000000;
      wdog_mode_ff <= 1'b0;
    end else begin
      pre_ff <= tick ? '0 : pre_ff + 1'b1;
      if (restart || wdog_exp) begin
        win_ff <= 32'h00000000;
        wdog_mode_ff <= 1'b0;
      end else if (host_write && !wdog_mode_ff) begin
        win_ff <= 32'h00000000;
        wdog_mode_ff <= 1'b1;
      end else if (ctrl_ff[`CTRL_KICK] && wdog_mode_ff) begin
        win_ff <= 32'h00000000;
      end else if (timer_run && tick) begin
        win_ff <= win_ff + 32'h00000001;
      end
    end
  end

  // ------------------------------------------------------------
  // fault status, pulse, interrupts
  // ------------------------------------------------------------
  logic [$clog2(PULSE_CYCLES+1)-1:0] pulse_ff;
  wire [1:0] nxt_code = phase_ff == charger_ctrl_pkg::ph_fault ? `STATE_FAULT :
                        phase_ff == charger_ctrl_pkg::ph_done ? `STATE_DONE :
                        charging ? `STATE_CHARGING : `STATE_READY;
  assign pulse_start = long_exp;
  wire [3:0] evt = {wdog_exp, long_exp, phase_ff != nxt_phase && nxt_phase == charger_ctrl_pkg::ph_done,
                    restart};
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stat_code_ff <= `STATE_READY;
      stat_read_ff <= 1'b1;
      pulse_ff <= '0;
      irq_stat_ff <= 4'h0;
    end else begin
      if (rd_status)
        stat_read_ff <= 1'b1;
      else if (stat_code_ff == `STATE_FAULT)
        stat_read_ff <= 1'b0;
      if (stat_read_ff || long_exp)
        stat_code_ff <= long_exp ? `STATE_FAULT : nxt_code;
      if (pulse_start)
        pulse_ff <= ($clog2(PULSE_CYCLES+1))'(PULSE_CYCLES);
      else if (pulse_ff != '0)
        pulse_ff <= pulse_ff - 1'b1;
      irq_stat_ff <= (irq_stat_ff & ~(wr_istat ? reg_wdata[3:0] : 4'h0)) | evt;
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ------------------------------------------------------------
  // indicator and power stage
  // ------------------------------------------------------------
  // indicator drive
  assign stat_out = 1'b0;
  assign stat_oe_n = !((charging && ctrl_ff[`CTRL_STAT_EN]) || pulse_ff != '0);
  assign charge_on = charging;
  assign short_current = charging && phase_ff == charger_ctrl_pkg::ph_short;
  assign fast_current = charging && phase_ff == charger_ctrl_pkg::ph_fast;
  assign boost_on = mode == charger_ctrl_pkg::mode_boost_type;
  assign hiz_on = mode == charger_ctrl_pkg::mode_hiz_type;
  assign vreg_target_mv = vreg_ff;
  logic [15:0] pwm_ff;
  wire [15:0] pwm_last = 16'(`PWM_PERIOD_CYCLES - 1);
  wire [31:0] on_cycles = (32'(duty_ff) * 32'(`PWM_PERIOD_CYCLES)) / 32'd1000;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      pwm_ff <= 16'h0000;
    else
      pwm_ff <= pwm_ff == pwm_last ? 16'h0000 : pwm_ff + 16'h0001;
  end
  wire switching = charging || boost_on;
  assign high_side_on = switching && 32'(pwm_ff) < on_cycles;
  assign low_side_on = switching && !high_side_on && sense_ff.low_side_over;
endmodule

//--- hdl/charger_ctrl_params.svh
// constants for the charger mode and safety timer block
// assumes a 250 MHz system clock
`ifndef CHARGER_CTRL_PARAMS_SVH
`define CHARGER_CTRL_PARAMS_SVH
`define CLK_MHZ 250
`define PRESCALE_US 64
`define PRESCALE_CYCLES (`PRESCALE_US * `CLK_MHZ)
`define LONG_WINDOW_S 900
`define LONG_WINDOW_TICKS ((`LONG_WINDOW_S * 1000000) / `PRESCALE_US)
`define WDOG_WINDOW_S 32
`define WDOG_WINDOW_TICKS ((`WDOG_WINDOW_S * 1000000) / `PRESCALE_US)
`define FAULT_PULSE_NS 128000
`define FAULT_PULSE_CYCLES ((`FAULT_PULSE_NS * `CLK_MHZ) / 1000)
`define PWM_FREQ_KHZ 3000
`define PWM_PERIOD_CYCLES ((`CLK_MHZ * 1000) / `PWM_FREQ_KHZ)
`define DUTY_MAX_PERMILLE 995
`define VREG_MIN_MV 3500
`define VREG_MAX_MV 4440
`define VREG_DEFAULT_MV 3540
`define ADDR_CTRL 4'h0
`define ADDR_VREG 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_IRQ_STAT 4'h3
`define ADDR_IRQ_MASK 4'h4
`define ADDR_DUTY 4'h5
`define CTRL_CHG_EN 0
`define CTRL_TERM_EN 1
`define CTRL_STAT_EN 2
`define CTRL_HIZ 3
`define CTRL_BOOST 4
`define CTRL_RESET 5
`define CTRL_KICK 6
`define CTRL_RESET_VAL 8'h06
`define STATE_READY 2'h0
`define STATE_CHARGING 2'h1
`define STATE_DONE 2'h2
`define STATE_FAULT 2'h3
`endif

//--- hdl/charger_ctrl_pkg.sv
// types for the charger mode and safety timer block
// used with charger_ctrl_params.svh
package charger_ctrl_pkg;
  typedef enum logic [1:0] {mode_hiz_type, mode_charge_type, mode_boost_type} op_mode_type;
  typedef enum logic [2:0] {ph_idle, ph_short, ph_fast, ph_done, ph_fault} phase_type;
  typedef struct packed {
    logic below_short;
    logic below_reg;
    logic below_recharge;
    logic below_lowbat;
    logic term_current;
    logic low_side_over;
  } sense_type;
endpackage

//--- testbench/host_link_model.sv
// host side of the serial control link: while send is held, every second link clock raises one write edge
// link_clk comes from the bench and is unrelated to the system clock
`timescale 1ns/1ps
module host_link_model (
  input wire logic link_clk,
  input wire logic send,
  output logic host_write_evt
);
  initial host_write_evt = 1'b0;
  always @(posedge link_clk) begin
    host_write_evt <= send && !host_write_evt;
  end
endmodule

//--- testbench/charger_ctrl_assertions.sv
// port level checker for the charger mode and safety timer block
// bound to charger_ctrl, watches its ports only
`timescale 1ns/1ps
module charger_ctrl_assertions #(
  parameter bit HAS_BOOST = 1'b1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire charger_ctrl_pkg::sense_type sense_in,
  input wire logic stat_out,
  input wire logic charge_on,
  input wire logic short_current,
  input wire logic fast_current,
  input wire logic boost_on,
  input wire logic hiz_on,
  input wire logic high_side_on,
  input wire logic low_side_on,
  input wire logic [15:0] vreg_target_mv
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_short_held;
    sense_in.below_short [*6];
  endsequence
  sequence s_fast_held;
    (!sense_in.below_short && sense_in.below_reg) [*6];
  endsequence
  sequence s_status_rd;
    reg_rd && reg_addr == 4'h2;
  endsequence
  a_hiz_halts: assert property (hiz_on |-> !charge_on && !boost_on)
    else $error("converter active in hiz");
  a_idle_no_switch: assert property (!charge_on && !boost_on |-> !high_side_on)
    else $error("switching while halted");
  a_boost_only: assert property (boost_on |-> HAS_BOOST && !charge_on)
    else $error("boost where not allowed");
  a_short_current: assert property (s_short_held ##0 charge_on |-> short_current)
    else $error("no reduced current below short level");
  a_fast_current: assert property (s_fast_held ##0 charge_on |-> fast_current)
    else $error("no fast current above short level");
  a_low_side_off: assert property ((!sense_in.low_side_over) [*4] |-> !low_side_on)
    else $error("low side on below threshold");
  a_stat_level: assert property (stat_out == 1'b0)
    else $error("indicator driven high");
  a_vreg_range: assert property (vreg_target_mv inside {[16'h0DAC:16'h1158]})
    else $error("regulation target out of range");
  a_fault_off: assert property (s_status_rd ##1 reg_rdata[1:0] == 2'h3 |-> !charge_on)
    else $error("charging with fault code");
endmodule
bind charger_ctrl charger_ctrl_assertions #(.HAS_BOOST(HAS_BOOST)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sense_in(sense_in), .stat_out(stat_out), .charge_on(charge_on),
  .short_current(short_current), .fast_current(fast_current), .boost_on(boost_on),
  .hiz_on(hiz_on), .high_side_on(high_side_on), .low_side_on(low_side_on),
  .vreg_target_mv(vreg_target_mv)
);

//--- testbench/charger_ctrl_test.sv
// self-checking bench for charger_ctrl with shortened timer parameters
// host link model drives the write events on a 160 ns link clock
`timescale 1ns/1ps
`include "charger_ctrl_params.svh"
module charger_ctrl_test;
  localparam int PULSE = 8;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic send = 1'b0;
  charger_ctrl_pkg::sense_type sense = '0;
  logic [15:0] reg_rdata, vreg_target_mv, rv;
  logic host_write_evt, irq, stat_out, stat_oe_n, charge_on, short_current, fast_current;
  logic boost_on, hiz_on, high_side_on, low_side_on;
  int num_errors = 0;
  int n_compared = 0;
  int v, k;
  charger_ctrl #(.PRESCALE(4), .LONG_TICKS(40), .WDOG_TICKS(25), .PULSE_CYCLES(PULSE)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_write_evt(host_write_evt),
    .sense_in(sense), .irq(irq), .stat_out(stat_out), .stat_oe_n(stat_oe_n),
    .charge_on(charge_on), .short_current(short_current), .fast_current(fast_current),
    .boost_on(boost_on), .hiz_on(hiz_on), .high_side_on(high_side_on),
    .low_side_on(low_side_on), .vreg_target_mv(vreg_target_mv));
  host_link_model host (.link_clk(link_clk), .send(send), .host_write_evt(host_write_evt));
  initial forever #2 sys_clk = ~sys_clk;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    end_sim();
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    check(rv & m, e);
  endtask
  task automatic host_write();
    @(posedge sys_clk);
    send <= 1'b1;
    for (k = 0; k < 100 && host_write_evt !== 1'b1; k++) @(posedge sys_clk);
    if (host_write_evt !== 1'b1) timeout();
    send <= 1'b0;
    for (k = 0; k < 100 && host_write_evt !== 1'b0; k++) @(posedge sys_clk);
    if (host_write_evt !== 1'b0) timeout();
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask
  function automatic logic [15:0] clip(input int x);
    return 16'((x < 3500) ? 3500 : (x > 4440) ? 4440 : x);
  endfunction
  initial begin
    repeat (60000) @(posedge sys_clk);
    timeout();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(36));
    do_reset();
    rchk(4'h0, 16'h007F, 16'h0006);
    rchk(4'h1, 16'hFFFF, 16'h0DD4);
    wr(4'hF, 16'hFFFF);
    rchk(4'hF, 16'hFFFF, 16'h0000);
    rchk(4'h0, 16'h007F, 16'h0006);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 3000 : (i == 1) ? 5000 : 3500 + $urandom % 941;
      wr(4'h1, v[15:0]);
      rchk(4'h1, 16'hFFFF, clip(v));
    end
    sense <= 6'h04;
    wr(4'h0, 16'h0016);
    cyc(2);
    check(16'(boost_on), 16'h0001);
    wr(4'h5, 16'h07D0);
    rchk(4'h5, 16'hFFFF, 16'(`DUTY_MAX_PERMILLE));
    wr(4'h5, 16'h01F4);
    v = 0;
    for (int i = 0; i < `PWM_PERIOD_CYCLES; i++) begin
      cyc(1);
      if (high_side_on === 1'b1) v++;
    end
    check(16'(v), 16'((16'h01F4 * `PWM_PERIOD_CYCLES) / 1000));
    wr(4'h0, 16'h001E);
    cyc(2);
    check(16'({hiz_on, boost_on, charge_on}), 16'h0004);
    wr(4'h0, 16'h0006);
    $display("test registers done");
    wr(4'h4, 16'h0000);
    sense <= 6'h34;
    wr(4'h0, 16'h0007);
    cyc(8);
    rchk(4'h2, 16'h0003, 16'h0001);
    check(16'({short_current, stat_oe_n}), 16'h0002);
    rchk(4'h3, 16'h0001, 16'h0001);
    check(16'(irq), 16'h0000);
    wr(4'h4, 16'h000F);
    cyc(2);
    check(16'(irq), 16'h0001);
    wr(4'h3, 16'h000F);
    cyc(2);
    check(16'(irq), 16'h0000);
    sense <= 6'h15;
    cyc(8);
    check(16'(fast_current), 16'h0001);
    $display("test charge start done");
    host_write();
    rchk(4'h2, 16'h0040, 16'h0040);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 16'h0047);
      cyc(40);
      rchk(4'h0, 16'h0040, 16'h0000);
    end
    rchk(4'h2, 16'h0040, 16'h0040);
    sense <= 6'h02;
    cyc(8);
    rchk(4'h2, 16'h0003, 16'h0002);
    rchk(4'h3, 16'h0002, 16'h0002);
    sense <= 6'h18;
    cyc(8);
    rchk(4'h2, 16'h0003, 16'h0001);
    wr(4'h1, 16'h1068);
    cyc(150);
    rchk(4'h1, 16'hFFFF, 16'h0DD4);
    rchk(4'h2, 16'h0040, 16'h0000);
    rchk(4'h3, 16'h0008, 16'h0008);
    check(16'(hiz_on), 16'h0001);
    $display("test watchdog done");
    do_reset();
    sense <= 6'h34;
    wr(4'h0, 16'h0007);
    v = 0;
    for (int i = 0; i < 400; i++) begin
      cyc(1);
      if (stat_oe_n === 1'b0 && charge_on === 1'b0) v++;
    end
    check(16'(v >= PULSE && v <= PULSE + 2), 16'h0001);
    rchk(4'h2, 16'h0003, 16'h0003);
    rchk(4'h3, 16'h0004, 16'h0004);
    check(16'({charge_on, stat_oe_n}), 16'h0001);
    sense <= 6'h14;
    wr(4'h0, 16'h0006);
    wr(4'h0, 16'h0007);
    host_write();
    cyc(8);
    rchk(4'h2, 16'h0003, 16'h0003);
    do_reset();
    rchk(4'h2, 16'h0003, 16'h0000);
    cyc(8);
    rchk(4'h2, 16'h0003, 16'h0001);
    $display("test long window fault done");
    end_sim();
  end
endmodule
